// ===== watchdog_pkg.sv
// Shared constants of the watchdog timeout unit: register map, fields and timing.
`default_nettype none
package watchdog_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CONTROL = 8'h1C;  // Main control and flag register
  localparam logic [7:0] OFF_STATUS  = 8'h20;  // Sticky event status, write one to clear
  localparam logic [7:0] OFF_MASK    = 8'h24;  // Interrupt mask, same layout as status
  localparam logic [7:0] OFF_COUNT   = 8'h28;  // Live counter value, read only

  // Control register field positions
  localparam int BIT_RESTART   = 0;   // Restart strobe, self clearing
  localparam int BIT_RST_EN    = 1;   // System reset enable
  localparam int BIT_RST_FLAG  = 2;   // Reset happened flag
  localparam int BIT_IRQ_FLAG  = 3;   // Timeout happened flag
  localparam int BIT_INTV_LO   = 4;   // Interval select, low bit
  localparam int BIT_INTV_HI   = 5;   // Interval select, high bit
  localparam int BIT_IRQ_EN    = 6;   // Interrupt enable
  localparam int BIT_ENABLE    = 7;   // Counter enable
  localparam int BIT_TEST      = 8;   // Test mode select
  localparam int BIT_PRESCALE  = 10;  // Divide-by-256 select

  // Status and mask bit positions
  localparam int EVT_TIMEOUT = 0;  // Interrupt timeout reached
  localparam int EVT_RESET   = 1;  // System reset requested
  localparam int EVT_COUNT   = 2;  // Number of event bits

  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0400;  // Prescale on, all else off
  localparam logic [1:0]  MASK_RESET    = 2'h0;           // All events masked

  // Interval select codes
  localparam logic [1:0] INTV_SHORT = 2'h0;  // 2^14 clocks
  localparam logic [1:0] INTV_MID   = 2'h1;  // 2^16 clocks
  localparam logic [1:0] INTV_LONG  = 2'h2;  // 2^18 clocks

  // Timing in watchdog clocks
  localparam int unsigned TIMEOUT_SHORT_CLOCKS = 16384;   // 2^14
  localparam int unsigned TIMEOUT_MID_CLOCKS   = 65536;   // 2^16
  localparam int unsigned TIMEOUT_LONG_CLOCKS  = 262144;  // 2^18
  localparam int unsigned RESET_GRACE_CLOCKS   = 16128;   // Timeout to reset
  localparam logic [7:0]  PRESCALE_LAST        = 8'hFF;   // Divide by 256
  localparam logic [1:0]  RESTART_HOLD         = 2'h3;    // Restart bit reads one this long
  localparam logic [9:0]  HALF_LAST            = 10'h3FF; // Test mode half-counter top

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Access done
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address

  // Counter sequence, Gray along the usual path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // Disabled
    ST_COUNT = 2'b01,  // Counting toward interrupt timeout
    ST_GRACE = 2'b11,  // Counting toward reset timeout
    ST_HALT  = 2'b10   // Grace over, reset disabled, waiting
  } dog_state_t;
endpackage
`default_nettype wire

// ===== wdt_ctrl_if.sv
// Carrier between the register side and the counter core.
`timescale 1ns/1ps
`default_nettype none
interface wdt_ctrl_if;
  logic        run;          // Counter enable
  logic        test_mode;    // Split-counter test mode
  logic        prescale_div; // Divide-by-256 select
  logic        reset_en;     // Reset request allowed
  logic        restart;      // Return counter to start
  logic [1:0]  interval;     // Interval select code
  logic        timeout_evt;  // One-cycle timeout pulse
  logic        reset_evt;    // One-cycle reset pulse
  logic [19:0] count;        // Live counter value

  // Register side drives controls
  modport regs (output run, test_mode, prescale_div, reset_en, restart, interval,
                input timeout_evt, reset_evt, count);
  // Core drives events
  modport core (input run, test_mode, prescale_div, reset_en, restart, interval,
                output timeout_evt, reset_evt, count);
endinterface
`default_nettype wire

// ===== wdt_counter_core.sv
// Watchdog counter core: prescaler, interval counter, grace counter, test mode.
`timescale 1ns/1ps
`default_nettype none
module wdt_counter_core #(
  parameter int unsigned TIMEOUT_SHORT = watchdog_pkg::TIMEOUT_SHORT_CLOCKS,
  parameter int unsigned TIMEOUT_MID   = watchdog_pkg::TIMEOUT_MID_CLOCKS,
  parameter int unsigned TIMEOUT_LONG  = watchdog_pkg::TIMEOUT_LONG_CLOCKS,
  parameter int unsigned RESET_GRACE   = watchdog_pkg::RESET_GRACE_CLOCKS
) (
  input  wire logic   clk,     // Watchdog clock
  input  wire logic   rst_n,   // Synchronous reset, active low
  wdt_ctrl_if.core    bus      // Controls in, events out
);
  localparam logic [19:0] SHORT_LAST = 20'(TIMEOUT_SHORT - 1);  // Last count, short
  localparam logic [19:0] MID_LAST   = 20'(TIMEOUT_MID - 1);    // Last count, mid
  localparam logic [19:0] LONG_LAST  = 20'(TIMEOUT_LONG - 1);   // Last count, long
  localparam logic [19:0] GRACE_LAST = 20'(RESET_GRACE - 1);    // Last grace count

  logic [7:0]               pre_cnt;  // Prescaler
  logic                     tick;     // One watchdog count step
  logic [19:0]              cnt;      // Main counter
  logic [19:0]              limit;    // Selected last count
  watchdog_pkg::dog_state_t state;    // Sequence state
  logic [9:0]               half_nx [2];  // Next values of the test halves

  assign bus.count = cnt;

  // Prescaler runs only while enabled; cleared with the counter
  always_ff @(posedge clk) begin
    if (!rst_n || !bus.run || bus.restart) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // Undivided in test mode or with prescale off
  assign tick = bus.test_mode || !bus.prescale_div ||
                (pre_cnt == watchdog_pkg::PRESCALE_LAST);

  // Interval decode, code 11 acts as the longest
  always_comb begin
    case (bus.interval)
      watchdog_pkg::INTV_SHORT: limit = SHORT_LAST;
      watchdog_pkg::INTV_MID:   limit = MID_LAST;
      default:                  limit = LONG_LAST;
    endcase
  end

  // Two independent 10-bit halves for test mode
  for (genvar h = 0; h < 2; h++) begin : g_half
    assign half_nx[h] = cnt[h*10 +: 10] + 10'h001;
  end

  // Count sequence and event pulses
  always_ff @(posedge clk) begin
    bus.timeout_evt <= 1'b0;
    bus.reset_evt   <= 1'b0;
    if (!rst_n || !bus.run) begin
      state <= watchdog_pkg::ST_IDLE;
      cnt   <= '0;
    end else if (bus.restart) begin
      state <= watchdog_pkg::ST_COUNT;
      cnt   <= '0;
    end else if (bus.test_mode) begin
      // Split counters, either overflow raises timeout
      state <= watchdog_pkg::ST_COUNT;
      cnt   <= {half_nx[1], half_nx[0]};
      if (cnt[9:0] == watchdog_pkg::HALF_LAST || cnt[19:10] == watchdog_pkg::HALF_LAST) begin
        bus.timeout_evt <= 1'b1;
      end
    end else begin
      case (state)
        watchdog_pkg::ST_IDLE: begin
          state <= watchdog_pkg::ST_COUNT;
        end
        watchdog_pkg::ST_COUNT: begin
          if (tick && cnt == limit) begin
            cnt             <= '0;
            bus.timeout_evt <= 1'b1;
            state           <= watchdog_pkg::ST_GRACE;
          end else if (tick) begin
            cnt <= cnt + 20'h0_0001;
          end
        end
        watchdog_pkg::ST_GRACE: begin
          if (tick && cnt == GRACE_LAST) begin
            cnt <= '0;
            if (bus.reset_en) begin
              bus.reset_evt <= 1'b1;
              state         <= watchdog_pkg::ST_COUNT;
            end else begin
              state <= watchdog_pkg::ST_HALT;
            end
          end else if (tick) begin
            cnt <= cnt + 20'h0_0001;
          end
        end
        default: begin
          state <= watchdog_pkg::ST_HALT;  // Wait for restart or disable
        end
      endcase
    end
  end
endmodule // wdt_counter_core
`default_nettype wire

// ===== watchdog_timeout_unit.sv
// Watchdog timeout unit top: AXI4-Lite registers, flags, interrupt and reset request.
//
// Behaviour
// - Test-mode select chooses normal or test operation.
// - Enable low stops and clears the counter.
// - Interrupt output only while interrupt enabled.
// - Interval select gives 2^14, 2^16, 2^18 clocks.
// - Reset comes 16128 clocks after the timeout.
// - Timeout sets the interrupt flag.
// - Flag sets even with interrupt disabled.
// - Flags ignore zero writes, clear on one.
// - Sticky reset flag survives the system reset.
// - Reset disabled: no reset, flag untouched.
// - Reset enable bit gates the reset function.
// - Restart bit clears counter, self-clears later.
// - Prescale divides by 256, never in test.
// - Test mode: two 10-bit counters, overflow interrupts.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_unit #(
  parameter int unsigned TIMEOUT_SHORT = watchdog_pkg::TIMEOUT_SHORT_CLOCKS, // Short interval
  parameter int unsigned TIMEOUT_MID   = watchdog_pkg::TIMEOUT_MID_CLOCKS,   // Mid interval
  parameter int unsigned TIMEOUT_LONG  = watchdog_pkg::TIMEOUT_LONG_CLOCKS,  // Long interval
  parameter int unsigned RESET_GRACE   = watchdog_pkg::RESET_GRACE_CLOCKS    // Grace period
) (
  input  wire logic        aclk,             // Bus and watchdog clock
  input  wire logic        aresetn,          // Synchronous reset, active low
  input  wire logic        power_on_resetn,  // Power-on reset, clears reset flag
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,     // Write byte address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Byte enables
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  // Write response channel
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,     // Read byte address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  // Read data channel
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  // System side
  output logic             irq,              // Level interrupt, active high
  output logic             sys_reset_req     // One-cycle reset request pulse
);

  // Control fields
  logic       test_mode_select;   // Test mode
  logic       dog_enable;         // Counter enable
  logic       dog_irq_enable;     // Interrupt enable
  logic [1:0] interval_select;    // Interval code
  logic       timeout_irq_flag;   // Timeout happened
  logic       dog_reset_flag;     // Reset happened, sticky
  logic       dog_reset_enable;   // Reset allowed
  logic       dog_restart;        // Restart strobe, reads one while held
  logic [1:0] restart_hold;       // Restart self-clear countdown
  logic       prescale_select;    // Divide-by-256

  // Interrupt registers
  logic [watchdog_pkg::EVT_COUNT-1:0] irq_status;  // Sticky events
  logic [watchdog_pkg::EVT_COUNT-1:0] irq_mask;    // Event mask
  logic [watchdog_pkg::EVT_COUNT-1:0] evt;         // Event pulses this cycle

  // Write channel holding
  logic        aw_held;   // Address captured
  logic [7:0]  aw_addr;   // Captured address
  logic        w_held;    // Data captured
  logic [31:0] w_data;    // Captured data
  logic [3:0]  w_strb;    // Captured strobes
  logic        do_write;  // Perform the write now

  // Write decode
  logic wr_control;  // Control register hit
  logic wr_status;   // Status register hit
  logic wr_mask;     // Mask register hit
  logic wr_mapped;   // Any mapped register hit
  logic lane0;       // Byte 0 enabled
  logic lane1;       // Byte 1 enabled

  // Read assembly
  logic [31:0] control_word;  // Control register as read
  logic [31:0] next_rdata;    // Read mux result
  logic [1:0]  next_rresp;    // Read response

  // Core link
  wdt_ctrl_if core_bus ();

  // Counter core instance
  wdt_counter_core #(
    .TIMEOUT_SHORT (TIMEOUT_SHORT),
    .TIMEOUT_MID   (TIMEOUT_MID),
    .TIMEOUT_LONG  (TIMEOUT_LONG),
    .RESET_GRACE   (RESET_GRACE)
  ) u_core (
    .clk   (aclk),
    .rst_n (aresetn),
    .bus   (core_bus.core)
  );

  // Controls to the core
  assign core_bus.run          = dog_enable;
  assign core_bus.test_mode    = test_mode_select;
  assign core_bus.prescale_div = prescale_select;
  assign core_bus.reset_en     = dog_reset_enable;
  assign core_bus.restart      = dog_restart;
  assign core_bus.interval     = interval_select;

  // Events from the core
  assign evt[watchdog_pkg::EVT_TIMEOUT] = core_bus.timeout_evt;
  assign evt[watchdog_pkg::EVT_RESET]   = core_bus.reset_evt;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;  // Hold until paired with data
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
      end
      // Ready again once nothing is pending
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;  // Hold until paired with address
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (do_write) begin
        w_held <= 1'b0;
      end
      // Ready again once nothing is pending
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // Write goes when both halves are in and no response waits
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Write address decode
  always_comb begin
    wr_control = 1'b0;
    wr_status  = 1'b0;
    wr_mask    = 1'b0;
    wr_mapped  = 1'b1;
    if (aw_addr[7:2] == watchdog_pkg::OFF_CONTROL[7:2]) begin
      wr_control = do_write;
    end else if (aw_addr[7:2] == watchdog_pkg::OFF_STATUS[7:2]) begin
      wr_status = do_write;
    end else if (aw_addr[7:2] == watchdog_pkg::OFF_MASK[7:2]) begin
      wr_mask = do_write;
    end else if (aw_addr[7:2] == watchdog_pkg::OFF_COUNT[7:2]) begin
      wr_mapped = 1'b1;  // Read only, write ignored
    end else begin
      wr_mapped = 1'b0;  // Unmapped
    end
  end

  assign lane0 = w_strb[0];
  assign lane1 = w_strb[1];

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= watchdog_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;  // Response taken
    end
  end

  // Control fields, byte 0 and byte 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_mode_select <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::BIT_TEST];
      dog_enable       <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::BIT_ENABLE];
      dog_irq_enable   <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::BIT_IRQ_EN];
      interval_select  <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::BIT_INTV_HI:
                                                      watchdog_pkg::BIT_INTV_LO];
      dog_reset_enable <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::BIT_RST_EN];
      prescale_select  <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::BIT_PRESCALE];
    end else if (wr_control) begin
      if (lane0) begin
        dog_enable       <= w_data[watchdog_pkg::BIT_ENABLE];
        dog_irq_enable   <= w_data[watchdog_pkg::BIT_IRQ_EN];
        interval_select  <= w_data[watchdog_pkg::BIT_INTV_HI:watchdog_pkg::BIT_INTV_LO];
        dog_reset_enable <= w_data[watchdog_pkg::BIT_RST_EN];
      end
      if (lane1) begin
        test_mode_select <= w_data[watchdog_pkg::BIT_TEST];
        prescale_select  <= w_data[watchdog_pkg::BIT_PRESCALE];
      end
    end
  end

  // Restart strobe, held a few cycles then cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dog_restart  <= 1'b0;
      restart_hold <= '0;
    end else if (wr_control && lane0 && w_data[watchdog_pkg::BIT_RESTART]) begin
      dog_restart  <= 1'b1;
      restart_hold <= watchdog_pkg::RESTART_HOLD;
    end else if (restart_hold != 2'h0) begin
      restart_hold <= restart_hold - 2'h1;
      dog_restart  <= (restart_hold != 2'h1);
    end else begin
      dog_restart <= 1'b0;
    end
  end

  // Timeout flag, set regardless of interrupt enable; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_irq_flag <= 1'b0;
    end else if (core_bus.timeout_evt) begin
      timeout_irq_flag <= 1'b1;
    end else if (wr_control && lane0 && w_data[watchdog_pkg::BIT_IRQ_FLAG]) begin
      timeout_irq_flag <= 1'b0;
    end
  end

  // Reset flag lives on the power-on reset so it outlasts the system reset
  always_ff @(posedge aclk) begin
    if (!power_on_resetn) begin
      dog_reset_flag <= 1'b0;
    end else if (core_bus.reset_evt) begin
      dog_reset_flag <= 1'b1;
    end else if (wr_control && lane0 && w_data[watchdog_pkg::BIT_RST_FLAG]) begin
      dog_reset_flag <= 1'b0;
    end
  end

  // Sticky event status, write one to clear, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < watchdog_pkg::EVT_COUNT; i++) begin
        if (evt[i]) begin
          irq_status[i] <= 1'b1;
        end else if (wr_status && lane0 && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= watchdog_pkg::MASK_RESET;
    end else if (wr_mask && lane0) begin
      irq_mask <= w_data[watchdog_pkg::EVT_COUNT-1:0];
    end
  end

  // Interrupt output, silenced while interrupt disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= dog_irq_enable && ((irq_status & irq_mask) != '0);
    end
  end

  // System reset request, registered single pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= core_bus.reset_evt;
    end
  end

  // Control register as software sees it
  always_comb begin
    control_word                              = '0;
    control_word[watchdog_pkg::BIT_RESTART]   = dog_restart;
    control_word[watchdog_pkg::BIT_RST_EN]    = dog_reset_enable;
    control_word[watchdog_pkg::BIT_RST_FLAG]  = dog_reset_flag;
    control_word[watchdog_pkg::BIT_IRQ_FLAG]  = timeout_irq_flag;
    control_word[watchdog_pkg::BIT_INTV_HI:watchdog_pkg::BIT_INTV_LO] = interval_select;
    control_word[watchdog_pkg::BIT_IRQ_EN]    = dog_irq_enable;
    control_word[watchdog_pkg::BIT_ENABLE]    = dog_enable;
    control_word[watchdog_pkg::BIT_TEST]      = test_mode_select;
    control_word[watchdog_pkg::BIT_PRESCALE]  = prescale_select;
  end

  // Read address decode
  always_comb begin
    next_rdata = '0;
    next_rresp = watchdog_pkg::RESP_OKAY;
    if (s_axi_araddr[7:2] == watchdog_pkg::OFF_CONTROL[7:2]) begin
      next_rdata = control_word;
    end else if (s_axi_araddr[7:2] == watchdog_pkg::OFF_STATUS[7:2]) begin
      next_rdata[watchdog_pkg::EVT_COUNT-1:0] = irq_status;
    end else if (s_axi_araddr[7:2] == watchdog_pkg::OFF_MASK[7:2]) begin
      next_rdata[watchdog_pkg::EVT_COUNT-1:0] = irq_mask;
    end else if (s_axi_araddr[7:2] == watchdog_pkg::OFF_COUNT[7:2]) begin
      next_rdata[19:0] = core_bus.count;
    end else begin
      next_rresp = watchdog_pkg::RESP_SLVERR;  // Unmapped
    end
  end

  // Read address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= watchdog_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;  // One read at a time
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;  // Data taken
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;  // Idle, accept
    end
  end

endmodule // watchdog_timeout_unit
`default_nettype wire

// ===== wdt_checker_assertions.sv
// Port-level assertions for the watchdog timeout unit.
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic        sys_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken together
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_RST_ONE: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  AST_QUIET: assert property ($rose(aresetn) |-> !irq && !sys_reset_req && !s_axi_bvalid)
    else $error("outputs busy after reset");
  AST_B_AFTER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_AW_BUSY: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_BUSY: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read taken twice");
endmodule // wdt_checker
bind watchdog_timeout_unit wdt_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq, .sys_reset_req);
`default_nettype wire

// ===== watchdog_timeout_unit_test.sv
// Self-checking bench for the watchdog timeout unit.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_unit_test;
  logic aclk = 0, aresetn = 0, power_on_resetn = 0, irq, sys_reset_req;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] wq[$], rq[$];  // Expected responses, oldest first
  int num_errors = 0, comparisons = 0, cyc = 0, pulses = 0, t, t0, n, tt[4] = '{64, 128, 256, 256};
  always #12.5 aclk = ~aclk;
  watchdog_timeout_unit #(.TIMEOUT_SHORT(64), .TIMEOUT_MID(128), .TIMEOUT_LONG(256),
    .RESET_GRACE(32)) uut (.aclk, .aresetn, .power_on_resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .sys_reset_req);
  task chk(string nm, logic [33:0] e, logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus write, each channel released when taken
  task wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = watchdog_pkg::RESP_OKAY);
    wq.push_back(34'(r));
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!(s_axi_bvalid && s_axi_bready));
  endtask
  // Bus read, ready held high, data taken at the valid edge
  task rd(logic [7:0] a, logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!(s_axi_rvalid && s_axi_rready));
  endtask
  task wait_irq;
    t = 0;
    while (irq !== 1'b1) begin
      @(posedge aclk);
      t++;
    end
  endtask
  // Response monitor, pulse counter and hang guard
  always @(posedge aclk) begin
    cyc++;
    if (sys_reset_req === 1'b1) pulses++;
    if (s_axi_bvalid && s_axi_bready) chk("bresp", wq.pop_front(), 34'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(98622));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    power_on_resetn <= 1;
    rd(8'h1C, {2'h0, watchdog_pkg::CONTROL_RESET});
    rd(8'h40, {watchdog_pkg::RESP_SLVERR, 32'h0});
    wr(8'h40, $urandom, watchdog_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1);
    wr(8'h1C, 32'h80);
    repeat (120) @(posedge aclk);
    chk("irq off", 0, irq);
    chk("pulses", 0, pulses);
    rd(8'h1C, 34'h88);
    wr(8'h1C, 32'h80);
    rd(8'h1C, 34'h88);
    wr(8'h1C, 32'hC8);
    repeat (3) @(posedge aclk);
    chk("irq on", 1, irq);
    wr(8'h24, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq masked", 0, irq);
    for (int c = 0; c < 4; c++) begin
      wr(8'h1C, 32'h0);
      wr(8'h20, 32'h3);
      wr(8'h24, 32'h1);
      wr(8'h1C, 32'hC2 | (c << 4));
      wait_irq();
      if (c == 0) t0 = t;
      chk("interval", tt[c] - tt[0], t - t0);
      n = 0;
      while (sys_reset_req !== 1'b1) begin
        @(posedge aclk);
        n++;
      end
      chk("grace", 31, n);
    end
    rd(8'h1C, 34'hFE);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h1C, 34'h404);
    wr(8'h1C, 32'hC);
    wr(8'h20, 32'h3);
    wr(8'h24, 32'h1);
    rd(8'h1C, 34'h0);
    wr(8'h1C, 32'hC0);
    repeat (30 + $urandom % 20) @(posedge aclk);
    wr(8'h1C, 32'hC1);
    wait_irq();
    chk("restart", 1, t > t0 - 6 && t < t0 + 6);
    rd(8'h1C, 34'hC8);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h3);
    wr(8'h1C, 32'h5C0);
    wait_irq();
    chk("test mode", 1, t < 1100);
    tally_and_finish();
  end
endmodule // watchdog_timeout_unit_test
`default_nettype wire
